/* shared/srbm_pkg.sv */
// package for the supply regulator and battery monitor register bank
// assumes a 32-bit apb slave on pclk; 8-bit registers sit in the low bits
package srbm_pkg;

    // ----------------------------------------------------------------
    // register byte addresses (printed offsets 0x0c, 0x10, 0x11 -> index * 4)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_TRX_CTRL_TWO = 8'h0C;
    localparam logic [7:0] IDX_REG_CTRL     = 8'h10;
    localparam logic [7:0] IDX_MON_CTRL     = 8'h11;
    localparam logic [11:0] ADDR_TRX_CTRL_TWO = {2'b00, IDX_TRX_CTRL_TWO, 2'b00};
    localparam logic [11:0] ADDR_REG_CTRL     = {2'b00, IDX_REG_CTRL, 2'b00};
    localparam logic [11:0] ADDR_MON_CTRL     = {2'b00, IDX_MON_CTRL, 2'b00};
    localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h0_080;
    localparam logic [11:0] ADDR_IRQ_MASK     = 12'h0_084;
    localparam logic [11:0] ADDR_POWER_STATE  = 12'h0_088;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int BIT_ANALOG_BYPASS   = 7;
    localparam int BIT_ANALOG_SETTLED  = 6;
    localparam int BIT_DIGITAL_BYPASS  = 3;
    localparam int BIT_DIGITAL_SETTLED = 2;
    localparam int BIT_IDLE_KEEP_ON    = 6;
    localparam int BIT_ABOVE_THRESHOLD = 5;
    localparam int BIT_HIGH_RANGE      = 4;
    localparam int IRQ_BATTERY_LOW     = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_TRX_CTRL_TWO = 8'h24;
    localparam logic [7:0] RST_REG_CTRL     = 8'h00;
    localparam logic [7:0] RST_MON_CTRL     = 8'h02;
    localparam logic [7:0] RST_IRQ_MASK     = 8'h00;

    // writable bits per register
    localparam logic [7:0] WMASK_REG_CTRL = 8'hBB;
    localparam logic [7:0] WMASK_MON_CTRL = 8'h5F;

    // threshold bases and steps in mV
    localparam int STEP_HIGH_MV = 75;
    localparam int STEP_LOW_MV  = 50;
    localparam int BASE_HIGH_MV = 2550;
    localparam int BASE_LOW_MV  = 1700;

    // transceiver power states (as seen by this block)
    typedef enum logic [1:0] {
        SRBM_PWR_ON  = 2'b00,
        SRBM_IDLE    = 2'b01,
        SRBM_ACTIVE  = 2'b11,
        SRBM_SLEEP   = 2'b10
    } srbm_state_t;

    typedef struct packed {
        logic analog_enable;
        logic digital_enable;
    } srbm_reg_en_t;

endpackage

/* core/srbm_top.sv */
// supply regulator control and battery monitor register bank
// assumes: apb master on pclk; analog settle and comparator inputs are
// async and synchronised here; power state is given by the transceiver core
`timescale 1ns/10ps
module srbm_top
    import srbm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire srbm_state_t       power_state,
    input  wire logic              analog_settle_raw,
    input  wire logic              digital_settle_raw,
    input  wire logic              comparator_raw,
    output srbm_reg_en_t           regulator_enable,
    output logic                   threshold_high_range,
    output logic      [3:0]        threshold_select,
    output logic      [11:0]       threshold_mv,
    output logic                   irq
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] trx_ctrl_two;
    logic [7:0] reg_ctrl;
    logic [7:0] mon_ctrl;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic       supply_above_threshold;
    logic       flag_seen_high;
    logic [1:0] analog_sync;
    logic [1:0] digital_sync;
    logic [1:0] cmp_sync;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire access   = psel && penable;
    wire wr       = access && pwrite && pstrb[0];
    wire hit_trx  = (paddr == ADDR_TRX_CTRL_TWO[ADDR_W-1:0]);
    wire hit_reg  = (paddr == ADDR_REG_CTRL[ADDR_W-1:0]);
    wire hit_mon  = (paddr == ADDR_MON_CTRL[ADDR_W-1:0]);
    wire hit_ist  = (paddr == ADDR_IRQ_STATUS[ADDR_W-1:0]);
    wire hit_imk  = (paddr == ADDR_IRQ_MASK[ADDR_W-1:0]);
    wire hit_pwr  = (paddr == ADDR_POWER_STATE[ADDR_W-1:0]);
    wire mapped   = hit_trx | hit_reg | hit_mon | hit_ist | hit_imk | hit_pwr;

    // ----------------------------------------------------------------
    // regulator side
    // ----------------------------------------------------------------
    wire analog_bypass  = reg_ctrl[BIT_ANALOG_BYPASS];
    wire digital_bypass = reg_ctrl[BIT_DIGITAL_BYPASS];
    wire idle_keep_on   = trx_ctrl_two[BIT_IDLE_KEEP_ON];
    wire analog_wanted  = (power_state == SRBM_ACTIVE)
                        || (power_state == SRBM_IDLE && idle_keep_on);
    wire next_analog_en  = !analog_bypass && analog_wanted;
    wire next_digital_en = !digital_bypass;
    wire analog_ok  = analog_bypass || (analog_sync[1] && regulator_enable.analog_enable);
    // reaching this register proves the digital supply is up, so it reads one
    wire digital_ok = 1'b1;

    // ----------------------------------------------------------------
    // battery monitor
    // ----------------------------------------------------------------
    // comparator is analog: it already sees the threshold given by the outputs
    wire monitor_on  = (power_state == SRBM_IDLE) || (power_state == SRBM_ACTIVE);
    wire next_above  = monitor_on ? cmp_sync[1] : supply_above_threshold;
    // fall only counts when flag was really one; a zero after reset stays quiet
    wire low_event   = monitor_on && supply_above_threshold && !cmp_sync[1]
                     && flag_seen_high;
    wire [7:0] clr_bits   = (wr && hit_ist) ? pwdata[7:0] : 8'h00;
    wire [7:0] set_bits   = {7'b0, low_event};
    wire [7:0] next_status = (irq_status & ~clr_bits) | set_bits;
    wire hr_next   = mon_ctrl[BIT_HIGH_RANGE];
    wire [11:0] base_mv = hr_next ? 12'(BASE_HIGH_MV) : 12'(BASE_LOW_MV);
    wire [11:0] step_mv = hr_next ? 12'(STEP_HIGH_MV) : 12'(STEP_LOW_MV);
    wire [11:0] next_thr_mv = base_mv + 12'(step_mv * mon_ctrl[3:0]);

    wire [7:0] reg_rd = {analog_bypass, analog_ok, reg_ctrl[5:4],
                         digital_bypass, digital_ok, reg_ctrl[1:0]};
    wire [7:0] mon_rd = {1'b0, mon_ctrl[6], supply_above_threshold, mon_ctrl[4:0]};
    wire [7:0] rd_byte =
        hit_trx ? trx_ctrl_two :
        hit_reg ? reg_rd :
        hit_mon ? mon_rd :
        hit_ist ? irq_status :
        hit_imk ? irq_mask :
        hit_pwr ? {6'b0, power_state} : 8'h00;

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_sync  <= 2'b00;
            digital_sync <= 2'b00;
            cmp_sync     <= 2'b00;
        end else begin
            analog_sync  <= {analog_sync[0], analog_settle_raw};
            digital_sync <= {digital_sync[0], digital_settle_raw};
            cmp_sync     <= {cmp_sync[0], comparator_raw};
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trx_ctrl_two <= RST_TRX_CTRL_TWO;
            reg_ctrl     <= RST_REG_CTRL;
            mon_ctrl     <= RST_MON_CTRL;
            irq_mask     <= RST_IRQ_MASK;
        end else if (wr) begin
            if (hit_trx) begin
                trx_ctrl_two <= pwdata[7:0];
            end else if (hit_reg) begin
                reg_ctrl <= pwdata[7:0] & WMASK_REG_CTRL;
            end else if (hit_mon) begin
                mon_ctrl <= pwdata[7:0] & WMASK_MON_CTRL;
            end else if (hit_imk) begin
                irq_mask <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // monitor state and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_above_threshold <= 1'b0;
            flag_seen_high         <= 1'b0;
            irq_status             <= 8'h00;
            irq                    <= 1'b0;
        end else begin
            supply_above_threshold <= next_above;
            flag_seen_high         <= flag_seen_high | (monitor_on && cmp_sync[1]);
            irq_status             <= next_status;                           // set beats clear
            irq                    <= |(next_status & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // outputs and apb answer
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regulator_enable     <= '{analog_enable: 1'b0, digital_enable: 1'b1};
            threshold_high_range <= 1'b0;
            threshold_select     <= RST_MON_CTRL[3:0];
            // matches the reset select so the mv output never disagrees with it
            threshold_mv         <= 12'(BASE_LOW_MV + STEP_LOW_MV * int'(RST_MON_CTRL[3:0]));
            prdata               <= 32'h0000_0000;
            pready               <= 1'b0;
            pslverr              <= 1'b0;
        end else begin
            regulator_enable.analog_enable  <= next_analog_en;
            regulator_enable.digital_enable <= next_digital_en;
            threshold_high_range <= hr_next;
            threshold_select     <= mon_ctrl[3:0];
            threshold_mv         <= next_thr_mv;
            // no wait state: pready is registered from the setup cycle and is high in the first access cycle
            pready               <= psel && !penable;
            pslverr              <= psel && !penable && !mapped;
            prdata               <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte}
                                                                  : 32'h0000_0000;
        end
    end

endmodule // srbm_top

/* test/srbm_top_asserts.sv */
// checker for the regulator and supply monitor register bank
// assumes it is bound to srbm_top and sees only its ports
`timescale 1ns/10ps
module srbm_top_asserts
    import srbm_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire srbm_state_t       power_state,
    input wire srbm_reg_en_t      regulator_enable,
    input wire logic              threshold_high_range,
    input wire logic [3:0]        threshold_select,
    input wire logic [11:0]       threshold_mv,
    input wire logic              irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire setup  = psel && !penable;
    wire mapped = paddr inside {ADDR_TRX_CTRL_TWO, ADDR_REG_CTRL, ADDR_MON_CTRL,
                                ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_POWER_STATE};
    wire wr_mon = psel && penable && pready && pwrite && pstrb[0] && paddr == ADDR_MON_CTRL;
    wire frozen = power_state == SRBM_PWR_ON || power_state == SRBM_SLEEP;

    a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready held");
    a_ready_after_setup: assert property (setup |=> pready) else $error("no pready");
    a_err_unmapped: assert property (setup && !mapped |=> pslverr) else $error("no pslverr");
    a_err_mapped_quiet: assert property (setup && mapped |=> !pslverr) else $error("bad pslverr");
    a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_select_follows: assert property (wr_mon |=> ##1 threshold_select == $past(pwdata[3:0], 2)
        && threshold_high_range == $past(pwdata[4], 2)) else $error("select stale");
    a_threshold_value: assert property ($past(presetn) |-> threshold_mv == (threshold_high_range
        ? 12'(BASE_HIGH_MV + STEP_HIGH_MV * threshold_select)
        : 12'(BASE_LOW_MV + STEP_LOW_MV * threshold_select))) else $error("bad mv");
    a_analog_off_frozen: assert property (frozen [*2] |-> !regulator_enable.analog_enable)
        else $error("analog on while frozen");
    cover property (wr_mon);
    cover property ($rose(irq));
    cover property (pslverr);
endmodule // srbm_top_asserts

bind srbm_top srbm_top_asserts #(.ADDR_W(ADDR_W)) u_srbm_top_asserts (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_state(power_state), .regulator_enable(regulator_enable),
    .threshold_high_range(threshold_high_range), .threshold_select(threshold_select),
    .threshold_mv(threshold_mv), .irq(irq));

/* test/supply_regulator_battery_monitor_tb.sv */
// self-checking bench for the regulator and supply monitor register bank
// assumes srbm_top with a zero-wait apb slave on a 50 ns clock
`timescale 1ns/10ps
module supply_regulator_battery_monitor_tb
    import srbm_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [11:0] paddr = 12'h0_000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, irq, threshold_high_range, aset = 0, cmp = 0;
    logic [3:0] threshold_select;
    logic [11:0] threshold_mv;
    srbm_state_t ps = SRBM_PWR_ON;
    srbm_reg_en_t en;
    int mismatches = 0, n_compared = 0;
    always #25 pclk = ~pclk;
    srbm_top u_srbm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_state(ps), .analog_settle_raw(aset),
        .digital_settle_raw(1'b1), .comparator_raw(cmp), .regulator_enable(en),
        .threshold_high_range(threshold_high_range), .threshold_select(threshold_select),
        .threshold_mv(threshold_mv), .irq(irq));
    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); apb(1, a, d); endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic hold(input int n); repeat (n) @(posedge pclk); endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_vals;
        rdchk(ADDR_TRX_CTRL_TWO, 32'h0000_0024);
        rdchk(ADDR_REG_CTRL, 32'h0000_0004);
        rdchk(ADDR_MON_CTRL, 32'h0000_0002);
        rdchk(ADDR_IRQ_MASK, 32'h0000_0000);
        check(32'(en), 32'h1);
    endtask
    task automatic t_regulators;
        ps <= SRBM_ACTIVE; aset <= 1; hold(6);
        check(32'(en), 32'h3);
        rdchk(ADDR_REG_CTRL, 32'h0000_0044);
        wr(ADDR_REG_CTRL, 32'h0000_0088); hold(3);
        check(32'(en), 32'h0);
        rdchk(ADDR_REG_CTRL, 32'h0000_00cc);
        wr(ADDR_REG_CTRL, 32'h0000_0000); aset <= 0; hold(6);
        rdchk(ADDR_REG_CTRL, 32'h0000_0004);
        aset <= 1; ps <= SRBM_IDLE; hold(4);
        check(32'(en), 32'h1);
        wr(ADDR_TRX_CTRL_TWO, 32'h0000_0054); hold(4);
        check(32'(en), 32'h3);
        ps <= SRBM_ACTIVE;
    endtask
    task automatic t_threshold;
        for (int r = 0; r < 2; r++) for (int s = 0; s < 16; s += 15) begin
            wr(ADDR_MON_CTRL, 32'(r * 16 + s)); hold(2);
            check(32'(threshold_mv), 32'(r ? BASE_HIGH_MV + STEP_HIGH_MV * s
                                          : BASE_LOW_MV + STEP_LOW_MV * s));
        end
    endtask
    task automatic t_monitor;
        // flag never high yet: a supply low since reset must stay silent
        wr(ADDR_IRQ_MASK, 32'h0000_0001); hold(8);
        rdchk(ADDR_IRQ_STATUS, 32'h0000_0000);
        wr(ADDR_MON_CTRL, 32'h0000_000f); cmp <= 1; hold(8);
        rdchk(ADDR_MON_CTRL, 32'h0000_002f);
        cmp <= 0; hold(8);
        check(32'(irq), 32'h1);
        rdchk(ADDR_MON_CTRL, 32'h0000_000f);
        wr(ADDR_IRQ_STATUS, 32'h0000_0001); hold(2);
        check(32'(irq), 32'h0);
        ps <= SRBM_SLEEP; cmp <= 1; hold(8);
        rdchk(ADDR_MON_CTRL, 32'h0000_000f);
        ps <= SRBM_ACTIVE; hold(8);
        wr(ADDR_IRQ_MASK, 32'h0000_0000); cmp <= 0; hold(8);
        check(32'(irq), 32'h0);
        rdchk(ADDR_IRQ_STATUS, 32'h0000_0001);
        apb(0, 12'h0_0fc, 32'h0);
        check(rd, 32'h0);
        check(32'(er), 32'h1);
    endtask
    task automatic complete_run;
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        hold(2);
        presetn <= 1;
        t_reset_vals();
        t_regulators();
        t_threshold();
        t_monitor();
        complete_run();
    end
    initial begin
        #500000;
        mismatches++;
        complete_run();
    end
endmodule // supply_regulator_battery_monitor_tb
